/* File: core/gpe_pkg.sv */
package gpe_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [1:0] GPE_IDX_DATA   = 2'h0;
  localparam logic [1:0] GPE_IDX_DIR    = 2'h1;
  localparam logic [1:0] GPE_IDX_OPT    = 2'h2;
  localparam int         GPE_ADR_W      = 4;
  localparam logic [3:0] GPE_ADR_DATA   = {GPE_IDX_DATA, 2'h0};
  localparam logic [3:0] GPE_ADR_DIR    = {GPE_IDX_DIR, 2'h0};
  localparam logic [3:0] GPE_ADR_OPT    = {GPE_IDX_OPT, 2'h0};
  localparam int         GPE_W          = 8;
  localparam logic [7:0] GPE_RST_VAL    = 8'h00;
  // pin classes
  localparam logic [7:0] GPE_INT_FLOAT  = 8'h88;  // interrupt pins without pull-up
  localparam logic [7:0] GPE_INT_PULL   = 8'h77;  // interrupt pins with pull-up
  localparam int         GPE_SPECIAL    = 2;      // special_input_only_pin position
  localparam logic       GPE_FLASH_VAR  = 1'b1;   // 1 flash variant, 0 mask-ROM variant
endpackage

/* File: core/gpe_port.sv */
`timescale 1ns/10ps
// Overview of operation
// - dir/opt select floating, pull-up, open-drain, push-pull
// - no-pull interrupt pins: opt input floats, interrupts
// - pull interrupt pins: opt input pulls up, interrupts
// - flash variant: special pin pull-up input only
// - ROM variant: special pin floating input, outputs normal
// - wait mode freezes nothing; interrupt wakes device
// - halt mode leaves pins; interrupt wakes device
// - interrupt needs interrupt config and cleared mask
// - no event flag; config bits only enable
// - reset clears data, direction, option registers
// - data at base, direction +4, option +8
module gpe_port
  import gpe_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [GPE_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [GPE_W-1:0]     pin_i,
  output logic      [GPE_W-1:0]     pin_o,
  output logic      [GPE_W-1:0]     pin_oe_o,
  output logic      [GPE_W-1:0]     pin_pullup_o,
  input  wire logic                 irq_mask_i,
  input  wire logic                 low_power_i,
  output logic                      ext_irq_o,
  output logic                      wake_o
);

  logic [GPE_W-1:0] port_a_data;
  logic [GPE_W-1:0] port_a_direction;
  logic [GPE_W-1:0] port_a_option;
  logic [GPE_W-1:0] sync1;
  logic [GPE_W-1:0] sync2;
  logic [GPE_W-1:0] sync3;
  logic [GPE_W-1:0] pin_level;

  // three-stage pin sampler; a change is accepted when stages two and three agree
  always_ff @(posedge clk_i)
  begin
    sync1 <= pin_i;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  genvar g;
  generate
    for (g = 0; g < GPE_W; g++)
    begin : g_filt
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          pin_level[g] <= 1'b0;
        else if (sync2[g] == sync3[g])
          pin_level[g] <= sync3[g];
      end
    end
  endgenerate

  // bus decode
  wire              req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire              wr_lane = req & wb_we_i & wb_sel_i[0];
  wire              hit_dat = (wb_adr_i == GPE_ADR_DATA);
  wire              hit_dir = (wb_adr_i == GPE_ADR_DIR);
  wire              hit_opt = (wb_adr_i == GPE_ADR_OPT);

  // one-hot mask of a pin position, shared by the special-pin decodes
  function automatic logic [GPE_W-1:0] pin_bit(input int pos);
    pin_bit = 8'h01 << pos;
  endfunction

  // special pin: flash variant can never be an output
  wire [GPE_W-1:0]  out_ok  = GPE_FLASH_VAR ? ~pin_bit(GPE_SPECIAL) : 8'hFF;
  wire [GPE_W-1:0]  is_out  = port_a_direction & out_ok;

  // data read mixes latch for outputs and sampled level for inputs
  wire [GPE_W-1:0]  rd_data = (is_out & port_a_data) | (~is_out & pin_level);
  wire [GPE_W-1:0]  rd_mux  = hit_dat ? rd_data :
                              hit_dir ? port_a_direction :
                              hit_opt ? port_a_option : 8'h00;

  // pull-up: input with option set, except floating classes
  wire [GPE_W-1:0]  pull_ok = ~GPE_INT_FLOAT &
                              (GPE_FLASH_VAR ? 8'hFF : ~pin_bit(GPE_SPECIAL));
  wire [GPE_W-1:0]  spec_pu = GPE_FLASH_VAR ? pin_bit(GPE_SPECIAL) : 8'h00;
  wire [GPE_W-1:0]  next_pu = (~is_out & port_a_option & pull_ok) | spec_pu;

  // open-drain drives only low; push-pull drives both levels
  wire [GPE_W-1:0]  next_oe = is_out & (port_a_option | ~port_a_data);
  wire [GPE_W-1:0]  next_po = is_out & port_a_option & port_a_data;

  // interrupt source: input configured with option on an interrupt-capable pin
  wire [GPE_W-1:0]  int_cfg = ~is_out & port_a_option & (GPE_INT_FLOAT | GPE_INT_PULL);
  // level-sensitive on low pin level; no flag is stored
  wire              next_irq = |(int_cfg & ~pin_level) & ~irq_mask_i;

  // registers; low_power_i deliberately gating nothing but wake_o
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_a_data      <= GPE_RST_VAL;
      port_a_direction <= GPE_RST_VAL;
      port_a_option    <= GPE_RST_VAL;
    end
    else if (wr_lane)
    begin
      if (hit_dat)
        port_a_data <= wb_dat_i[7:0];
      if (hit_dir)
        port_a_direction <= wb_dat_i[7:0];
      if (hit_opt)
        port_a_option <= wb_dat_i[7:0];
    end
  end

  // outputs all from flops; wait/halt leave every pin and register as is
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      pin_o        <= 8'h00;
      pin_oe_o     <= 8'h00;
      pin_pullup_o <= 8'h00;
      ext_irq_o    <= 1'b0;
      wake_o       <= 1'b0;
    end
    else
    begin
      wb_ack_o     <= req;
      wb_dat_o     <= req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      pin_o        <= next_po;
      pin_oe_o     <= next_oe;
      pin_pullup_o <= next_pu;
      ext_irq_o    <= next_irq;
      wake_o       <= next_irq & low_power_i;
    end
  end

  // reset clears all three registers
  a_rst_clears: assert property (@(posedge clk_i)
    rst_i |=> (port_a_direction == 8'h00) && (port_a_option == 8'h00)
    && (port_a_data == 8'h00))
    else $error("registers not cleared by reset");

  // reset leaves every pin released and every strobe low
  a_rst_outputs: assert property (@(posedge clk_i)
    rst_i |=> !wb_ack_o && !ext_irq_o && !wake_o && (pin_oe_o == 8'h00))
    else $error("outputs not cleared by reset");

  // every new request is answered one cycle later
  a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  // ack is a single pulse; a held strobe is taken again every second cycle
  a_ack_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // read data is zero outside the ack cycle
  a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data outside acknowledge");

  // write at the base offset lands in the data register
  a_dat_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane && hit_dat) |=> (port_a_data == $past(wb_dat_i[7:0])))
    else $error("data register write lost");

  // write at base plus four lands in the direction register
  a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane && hit_dir) |=> (port_a_direction == $past(wb_dat_i[7:0])))
    else $error("direction register write lost");

  // write at base plus eight lands in the option register
  a_opt_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane && hit_opt) |=> (port_a_option == $past(wb_dat_i[7:0])))
    else $error("option register write lost");

  // unmapped reads return zero
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !hit_dat && !hit_dir && !hit_opt)
    |=> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read not zero");

  // an output pin reads back its latch
  a_read_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_dat && is_out[1])
    |=> (wb_dat_o[1] == $past(port_a_data[1])))
    else $error("output pin read does not return latch");

  // an input pin reads back the sampled level
  a_read_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_dat && !is_out[4])
    |=> (wb_dat_o[4] == $past(pin_level[4])))
    else $error("input pin read does not return level");

  // the sampled level takes stage three when stages two and three agree on every pin
  a_pin_filter: assert property (@(posedge clk_i) disable iff (rst_i)
    (sync2 == sync3) |=> (pin_level == $past(sync3)))
    else $error("pin level not taken from agreeing stages");

  // push-pull drives the latch value
  a_pushpull_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_a_direction[0] && port_a_option[0])
    |=> pin_oe_o[0] && (pin_o[0] == $past(port_a_data[0])))
    else $error("push-pull pin not driven");

  // push-pull drives a one actively
  a_pushpull_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_a_direction[6] && port_a_option[6] && port_a_data[6]) |=> pin_oe_o[6] && pin_o[6])
    else $error("push-pull high not driven");

  // open-drain pulls low on a zero
  a_opendrain_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_a_direction[1] && !port_a_option[1] && !port_a_data[1]) |=> pin_oe_o[1] && !pin_o[1])
    else $error("open-drain low not driven");

  // open-drain lets go on a one
  a_opendrain_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_a_direction[1] && !port_a_option[1] && port_a_data[1]) |=> !pin_oe_o[1])
    else $error("open-drain high driven");

  // floating input is neither driven nor pulled
  a_float_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (!port_a_direction[5] && !port_a_option[5]) |=> !pin_oe_o[5] && !pin_pullup_o[5])
    else $error("floating input pulled or driven");

  // an output never has its pull-up on
  a_out_no_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    port_a_direction[0] |=> !pin_pullup_o[0])
    else $error("output pin pulled up");

  // pins of the floating interrupt class never get a pull-up
  a_float_no_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_a_direction[3] |=> !pin_oe_o[3] && !pin_pullup_o[3])
    else $error("floating interrupt pin pulled or driven");

  // pull-up input on an interrupt pin with pull
  a_pull_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (!port_a_direction[0] && port_a_option[0]) |=> pin_pullup_o[0] && !pin_oe_o[0])
    else $error("pull-up input not pulled");

  // second pull-up interrupt pin, upper nibble
  a_pull_pin6: assert property (@(posedge clk_i) disable iff (rst_i)
    (!port_a_direction[6] && port_a_option[6]) |=> pin_pullup_o[6] && !pin_oe_o[6])
    else $error("upper pull-up input not pulled");

  // flash variant: special pin is a pulled input; checked from the second cycle after reset
  a_special_input: assert property (@(posedge clk_i) disable iff (rst_i)
    GPE_FLASH_VAR |=> !pin_oe_o[GPE_SPECIAL] && pin_pullup_o[GPE_SPECIAL])
    else $error("special pin driven on flash variant");

  // special pin push-pull drives only on the ROM variant
  a_special_output: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_a_direction[GPE_SPECIAL] && port_a_option[GPE_SPECIAL])
    |=> (pin_oe_o[GPE_SPECIAL] == !GPE_FLASH_VAR))
    else $error("special pin output capability wrong");

  // mask blocks every request
  a_irq_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_mask_i |=> !ext_irq_o)
    else $error("interrupt raised while masked");

  // floating interrupt pin low raises the request
  a_irq_float_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (int_cfg[3] && !pin_level[3] && !irq_mask_i) |=> ext_irq_o)
    else $error("floating interrupt pin ignored");

  // pull-up interrupt pin low raises the request
  a_irq_pull_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (int_cfg[0] && !pin_level[0] && !irq_mask_i) |=> ext_irq_o)
    else $error("pull-up interrupt pin ignored");

  // configuration is the only enable
  a_irq_needs_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    (int_cfg == 8'h00) |=> !ext_irq_o)
    else $error("interrupt without interrupt configuration");

  // no stored flag: the request drops as soon as its cause goes
  a_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !next_irq |=> !ext_irq_o)
    else $error("interrupt held without cause");

  // wake only with an interrupt in low power
  a_wake_follows_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> ext_irq_o && $past(low_power_i))
    else $error("wake without interrupt in low power");

  // an interrupt in low power always wakes
  a_wake_in_lp: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_power_i && next_irq) |=> wake_o)
    else $error("interrupt in low power did not wake");

  // no wake while running
  a_wake_needs_lp: assert property (@(posedge clk_i) disable iff (rst_i)
    !low_power_i |=> !wake_o)
    else $error("wake outside low power");

  // low power alone never moves a pin drive
  a_halt_pins_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_power_i && $stable(port_a_direction) && $stable(port_a_option)
     && $stable(port_a_data)) |=> $stable(pin_oe_o))
    else $error("pin drive changed in low power");

  // low power alone never moves a register
  a_lp_regs_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_power_i && !req) |=> $stable(port_a_data) && $stable(port_a_direction)
    && $stable(port_a_option))
    else $error("register changed in low power");

endmodule

/* File: sim/gpe_board.sv */
`timescale 1ns/10ps
// board side of the port: external drivers, pull resistor, loose lines
module gpe_board
  import gpe_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic [GPE_W-1:0] pin_o_i,
  input  wire logic [GPE_W-1:0] oe_i,
  input  wire logic [GPE_W-1:0] pull_i,
  input  wire logic [GPE_W-1:0] ext_en_i,
  input  wire logic [GPE_W-1:0] ext_val_i,
  output logic      [GPE_W-1:0] pad_o
);
  logic [GPE_W-1:0] float_q = 8'h00;
  // an undriven, unpulled line wanders each cycle, so no read may count on it
  always @(posedge clk_i)
    float_q <= ~float_q;
  // external driver wins over the port; the pull only acts on a released line
  assign pad_o = (ext_en_i & ext_val_i) | (~ext_en_i & oe_i & pin_o_i)
               | (~ext_en_i & ~oe_i & (pull_i | float_q));
endmodule

/* File: sim/tb_gpe_port.sv */
`timescale 1ns/10ps
module tb_gpe_port
  import gpe_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, mask = 1'b1, lp = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'h0000_9D91;
  logic [7:0]  ev = 8'h00, po, oe, pu, pad, dr, op, dt, e_oe, e_pu, e_o, eo;
  logic        ack, irq, wake;
  logic [31:0] expq[$];
  int          fails = 0, cmp_count = 0, cyc_n = 0;
  gpe_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_i(pad), .pin_o(po), .pin_oe_o(oe), .pin_pullup_o(pu), .irq_mask_i(mask),
    .low_power_i(lp), .ext_irq_o(irq), .wake_o(wake));
  gpe_board board (.clk_i(clk_i), .pin_o_i(po), .oe_i(oe), .pull_i(pu), .ext_en_i(8'hFF),
    .ext_val_i(ev), .pad_o(pad));
  initial
    forever #25 clk_i = ~clk_i;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the request stands until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, v};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  // read results are matched against the oldest note in the queue
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0) chk(rdat, expq.pop_front());
  // expected pad controls, bit by bit, from direction, option and data
  task automatic pins();
    for (int i = 0; i < GPE_W; i++)
    begin
      e_oe[i] = dr[i] & (op[i] | ~dt[i]);
      e_o[i] = dr[i] & op[i] & dt[i];
      e_pu[i] = ~dr[i] & op[i] & ~GPE_INT_FLOAT[i];
      if (i == GPE_SPECIAL && GPE_FLASH_VAR)
        {e_oe[i], e_o[i], e_pu[i]} = 3'b001;
    end
    repeat (2) @(posedge clk_i);
    chk(oe, e_oe);
    chk(pu, e_pu);
    chk(po & oe, e_o);
  endtask
  // interrupt is a level, so a bounded wait settles it
  task automatic irqw(input logic e);
    for (int k = 0; k < 8 && irq !== e; k++) @(posedge clk_i);
    chk(irq, e);
  endtask
  task automatic cfg(input logic [7:0] o, input logic [7:0] v);
    bus(1'b1, GPE_ADR_OPT, o);
    ev <= v;
  endtask
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 4000)
    begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    {dr, op, dt} = 24'h0;
    rd(GPE_ADR_DIR, GPE_RST_VAL);
    rd(GPE_ADR_OPT, GPE_RST_VAL);
    pins();
    $display("test reset done");
    for (int n = 0; n < 12; n++)
    begin
      dr = rnd(); op = rnd(); dt = rnd();
      bus(1'b1, GPE_ADR_DATA, dt);
      bus(1'b1, GPE_ADR_DIR, dr);
      bus(1'b1, GPE_ADR_OPT, op);
      rd(GPE_ADR_DIR, dr);
      rd(GPE_ADR_OPT, op);
      eo = dr & ~({7'h00, GPE_FLASH_VAR} << GPE_SPECIAL);
      rd(GPE_ADR_DATA, (eo & dt) | (~eo & ev));
      pins();
    end
    rd(4'hC, 8'h00);
    $display("test modes done");
    bus(1'b1, GPE_ADR_DIR, 8'h00);
    ev <= rnd();
    repeat (6) @(posedge clk_i);
    rd(GPE_ADR_DATA, ev);
    cfg(8'h88, 8'hF7);
    mask <= 1'b0;
    irqw(1'b1);
    mask <= 1'b1;
    irqw(1'b0);
    mask <= 1'b0; lp <= 1'b1;
    irqw(1'b1);
    chk(wake, 1'b1);
    cfg(8'h00, 8'hF7);
    irqw(1'b0);
    chk(wake, 1'b0);
    cfg(8'h01, 8'hFE);
    irqw(1'b1);
    ev <= 8'hFF;
    irqw(1'b0);
    $display("test interrupts done");
    close_out();
  end
endmodule
